/* fzcr_defs.vh */
// fzcr_defs.vh: offsets, field positions, reset values and timing for the fan zone and coefficient registers.
// assumes: included by bare name from the fzcr design files.
`ifndef FZCR_DEFS_VH
`define FZCR_DEFS_VH

`define FZCR_ADDR_TEMP_FIRST   8'h20
`define FZCR_ADDR_TEMP_LAST    8'h29
`define FZCR_ADDR_MAX_TEMP     8'h78
`define FZCR_ADDR_COEF_GOFF    8'h7a
`define FZCR_ADDR_COEF_OSPIN   8'h7b
`define FZCR_ADDR_FAN12_ZONE   8'h7c
`define FZCR_ADDR_FAN34_ZONE   8'h7d

`define FZCR_REG_RESET         8'h00
`define FZCR_RDATA_UNMAPPED    8'h00

`define FZCR_GAIN_LO_MSB       7
`define FZCR_GAIN_LO_LSB       6
`define FZCR_OFFS_HI_MSB       5
`define FZCR_OFFS_HI_LSB       0
`define FZCR_OFFS_LO_MSB       7
`define FZCR_OFFS_LO_LSB       5
`define FZCR_SPIN_MSB          2
`define FZCR_SPIN_LSB          0
`define FZCR_ZONE_HI_MSB       7
`define FZCR_ZONE_HI_LSB       4
`define FZCR_ZONE_LO_MSB       3
`define FZCR_ZONE_LO_LSB       0

`define FZCR_ZONE_MAX          4'h0
`define FZCR_ZONE_LAST_SENSOR  4'ha
`define FZCR_SPIN_NONE         3'h0

`define FZCR_CORE_CLK_MHZ      50
`define FZCR_SPIN_T1_US        100000
`define FZCR_SPIN_T2_US        250000
`define FZCR_SPIN_T3_US        400000
`define FZCR_SPIN_T4_US        667000
`define FZCR_SPIN_T5_US        1000000
`define FZCR_SPIN_T6_US        2000000
`define FZCR_SPIN_T7_US        4000000

`endif

/* fzcr_zone_mux.v */
// fzcr_zone_mux.v: picks one fan's controlling temperature from the sensor readings or their maximum.
// assumes: readings and maximum are stable registers of the enclosing block.
`timescale 1ns/10ps
`include "fzcr_defs.vh"

module fzcr_zone_mux #(
  parameter NUM_SENSORS = 10,
  parameter TEMP_W      = 8
) (
  input  wire [3:0]                    zone_sel,
  input  wire [NUM_SENSORS*TEMP_W-1:0] temps,
  input  wire [TEMP_W-1:0]             max_temp,
  output reg  [TEMP_W-1:0]             fan_temp
);
  always @* begin
    fan_temp = max_temp;
    // codes above the last sensor fall back to the maximum
    if ((zone_sel != `FZCR_ZONE_MAX) && (zone_sel <= `FZCR_ZONE_LAST_SENSOR)) begin
      fan_temp = temps[(zone_sel - 4'h1)*TEMP_W +: TEMP_W];
    end
  end
endmodule // fzcr_zone_mux

/* fzcr_regs.v */
// fzcr_regs.v: optional coefficient, spin-up and fan zone registers with max temperature, fan source
// selection, coefficient choice and per-fan spin-up timers.
// assumes: the serial management bus front end presents byte reads and writes on the REG_ ports,
// synchronous to CORE_CLK; sensor readings arrive already decoded.
//
// Notes on behaviour
// - bits 7:6 of 0x7a hold gain coefficient bits 1:0, read and write.
// - bits 5:0 of 0x7a hold offset coefficient bits 8:3, read and write.
// - bits 7:5 of 0x7b hold offset coefficient bits 2:0, making a nine-bit offset.
// - bits 2:0 of 0x7b are the spin-up code, and 000 means no spin-up phase.
// - codes 001 to 111 give spin-up times of 100, 250, 400, 667 ms, 1, 2 and 4 s on fan start.
// - bits 7:4 of 0x7c choose fan 1's source, 0000 the maximum and 1 to 10 a sensor.
// - bits 3:0 of 0x7c choose fan 2's source with the same coding.
// - bits 7:4 of 0x7d choose fan 3's source with the same coding.
// - bits 3:0 of 0x7d choose fan 4's source with the same coding.
// - code n routes the reading at address 0x20 plus n minus one, sensor 10 sitting at 0x29.
// - all four registers are 0x00 after reset.
// - 0x78 reads the largest of all sensor readings, read only, and is the source for code 0000.
// - a sensor uses the optional gain and offset only when its select bit is 1, else the defaults.
`timescale 1ns/10ps
`include "fzcr_defs.vh"

module fzcr_regs #(
  parameter NUM_SENSORS  = 10,
  parameter TEMP_W       = 8,
  parameter NUM_FANS     = 4,
  parameter DEF_GAIN     = 10'h000,
  parameter DEF_OFFSET   = 9'h000,
  parameter SPIN_T1_CYC  = `FZCR_SPIN_T1_US * `FZCR_CORE_CLK_MHZ,
  parameter SPIN_T2_CYC  = `FZCR_SPIN_T2_US * `FZCR_CORE_CLK_MHZ,
  parameter SPIN_T3_CYC  = `FZCR_SPIN_T3_US * `FZCR_CORE_CLK_MHZ,
  parameter SPIN_T4_CYC  = `FZCR_SPIN_T4_US * `FZCR_CORE_CLK_MHZ,
  parameter SPIN_T5_CYC  = `FZCR_SPIN_T5_US * `FZCR_CORE_CLK_MHZ,
  parameter SPIN_T6_CYC  = `FZCR_SPIN_T6_US * `FZCR_CORE_CLK_MHZ,
  parameter SPIN_T7_CYC  = `FZCR_SPIN_T7_US * `FZCR_CORE_CLK_MHZ
) (
  input  wire                          CORE_CLK,
  input  wire                          RESET_N,
  input  wire                          CORE_CE,
  input  wire [7:0]                    REG_ADDR,
  input  wire [7:0]                    REG_WDATA,
  input  wire                          REG_WR,
  input  wire                          REG_RD,
  output reg  [7:0]                    REG_RDATA,
  output reg                           REG_RVALID,
  input  wire [NUM_SENSORS*TEMP_W-1:0] SENSOR_TEMPS,
  input  wire [7:0]                    GAIN_COEF_HI,
  input  wire [NUM_SENSORS-1:0]        COEF_SELECT,
  input  wire [3:0]                    COEF_SENSOR_IDX,
  output reg  [9:0]                    GAIN_COEF,
  output reg  [8:0]                    OFFSET_COEF,
  output reg  [NUM_FANS*TEMP_W-1:0]    FAN_TEMPS,
  input  wire [NUM_FANS-1:0]           FAN_START,
  output wire [NUM_FANS-1:0]           FAN_SPINUP
);

  reg  [7:0]                 coef_option_gain_lo_offset_hi_q;
  reg  [7:0]                 coef_option_offset_lo_spinup_q;
  reg  [7:0]                 fan12_zone_select_q;
  reg  [7:0]                 fan34_zone_select_q;
  reg  [TEMP_W-1:0]          max_temp_q;
  reg  [TEMP_W-1:0]          max_temp_d;
  reg  [7:0]                 rdata_d;
  wire [9:0]                 optional_gain_coef;
  wire [8:0]                 optional_offset_coef;
  wire [2:0]                 spinup_duration_code;
  wire [3:0]                 fan_one_source_sel;
  wire [3:0]                 fan_two_source_sel;
  wire [3:0]                 fan_three_source_sel;
  wire [3:0]                 fan_four_source_sel;
  wire [4*NUM_FANS-1:0]      fan_sel_all;
  wire [NUM_FANS*TEMP_W-1:0] fan_temp_d;
  wire                       wr_en;
  wire                       rd_en;
  integer                    s;

  assign wr_en = CORE_CE & REG_WR;
  assign rd_en = CORE_CE & REG_RD;

  assign optional_gain_coef   = {GAIN_COEF_HI,
                                 coef_option_gain_lo_offset_hi_q[`FZCR_GAIN_LO_MSB:`FZCR_GAIN_LO_LSB]};
  assign optional_offset_coef = {coef_option_gain_lo_offset_hi_q[`FZCR_OFFS_HI_MSB:`FZCR_OFFS_HI_LSB],
                                 coef_option_offset_lo_spinup_q[`FZCR_OFFS_LO_MSB:`FZCR_OFFS_LO_LSB]};
  assign spinup_duration_code = coef_option_offset_lo_spinup_q[`FZCR_SPIN_MSB:`FZCR_SPIN_LSB];
  assign fan_one_source_sel   = fan12_zone_select_q[`FZCR_ZONE_HI_MSB:`FZCR_ZONE_HI_LSB];
  assign fan_two_source_sel   = fan12_zone_select_q[`FZCR_ZONE_LO_MSB:`FZCR_ZONE_LO_LSB];
  assign fan_three_source_sel = fan34_zone_select_q[`FZCR_ZONE_HI_MSB:`FZCR_ZONE_HI_LSB];
  assign fan_four_source_sel  = fan34_zone_select_q[`FZCR_ZONE_LO_MSB:`FZCR_ZONE_LO_LSB];
  assign fan_sel_all = {fan_four_source_sel, fan_three_source_sel, fan_two_source_sel, fan_one_source_sel};

  // host-writable registers
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      coef_option_gain_lo_offset_hi_q <= `FZCR_REG_RESET;
      coef_option_offset_lo_spinup_q  <= `FZCR_REG_RESET;
      fan12_zone_select_q             <= `FZCR_REG_RESET;
      fan34_zone_select_q             <= `FZCR_REG_RESET;
    end else if (wr_en) begin
      if (REG_ADDR == `FZCR_ADDR_COEF_GOFF) begin
        coef_option_gain_lo_offset_hi_q <= REG_WDATA;
      end else if (REG_ADDR == `FZCR_ADDR_COEF_OSPIN) begin
        coef_option_offset_lo_spinup_q <= REG_WDATA;
      end else if (REG_ADDR == `FZCR_ADDR_FAN12_ZONE) begin
        fan12_zone_select_q <= REG_WDATA;
      end else if (REG_ADDR == `FZCR_ADDR_FAN34_ZONE) begin
        fan34_zone_select_q <= REG_WDATA;
      end
    end
  end

  // maximum of all readings, registered so every fan sees one consistent value
  always @* begin
    max_temp_d = SENSOR_TEMPS[TEMP_W-1:0];
    for (s = 1; s < NUM_SENSORS; s = s + 1) begin
      if (SENSOR_TEMPS[s*TEMP_W +: TEMP_W] > max_temp_d) begin
        max_temp_d = SENSOR_TEMPS[s*TEMP_W +: TEMP_W];
      end
    end
  end

  // read decode; writes to read-only addresses are silently dropped
  always @* begin
    rdata_d = `FZCR_RDATA_UNMAPPED;
    if (REG_ADDR == `FZCR_ADDR_COEF_GOFF) begin
      rdata_d = coef_option_gain_lo_offset_hi_q;
    end else if (REG_ADDR == `FZCR_ADDR_COEF_OSPIN) begin
      rdata_d = coef_option_offset_lo_spinup_q;
    end else if (REG_ADDR == `FZCR_ADDR_FAN12_ZONE) begin
      rdata_d = fan12_zone_select_q;
    end else if (REG_ADDR == `FZCR_ADDR_FAN34_ZONE) begin
      rdata_d = fan34_zone_select_q;
    end else if (REG_ADDR == `FZCR_ADDR_MAX_TEMP) begin
      rdata_d = max_temp_q[7:0];
    end else if ((REG_ADDR >= `FZCR_ADDR_TEMP_FIRST) && (REG_ADDR <= `FZCR_ADDR_TEMP_LAST)) begin
      rdata_d = SENSOR_TEMPS[(REG_ADDR - `FZCR_ADDR_TEMP_FIRST)*TEMP_W +: 8];
    end
  end

  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      max_temp_q  <= {TEMP_W{1'b0}};
      REG_RDATA   <= 8'h00;
      REG_RVALID  <= 1'b0;
      GAIN_COEF   <= 10'h000;
      OFFSET_COEF <= 9'h000;
      FAN_TEMPS   <= {(NUM_FANS*TEMP_W){1'b0}};
    end else if (CORE_CE) begin
      max_temp_q <= max_temp_d;
      REG_RVALID <= rd_en;
      if (rd_en) begin
        REG_RDATA <= rdata_d;
      end
      // out-of-range index has no select bit, so it keeps the defaults
      if ((COEF_SENSOR_IDX < NUM_SENSORS) && COEF_SELECT[COEF_SENSOR_IDX]) begin
        GAIN_COEF   <= optional_gain_coef;
        OFFSET_COEF <= optional_offset_coef;
      end else begin
        GAIN_COEF   <= DEF_GAIN;
        OFFSET_COEF <= DEF_OFFSET;
      end
      FAN_TEMPS <= fan_temp_d;
    end
  end

  function [31:0] spin_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h1:    spin_cycles = SPIN_T1_CYC;
        3'h2:    spin_cycles = SPIN_T2_CYC;
        3'h3:    spin_cycles = SPIN_T3_CYC;
        3'h4:    spin_cycles = SPIN_T4_CYC;
        3'h5:    spin_cycles = SPIN_T5_CYC;
        3'h6:    spin_cycles = SPIN_T6_CYC;
        3'h7:    spin_cycles = SPIN_T7_CYC;
        default: spin_cycles = 32'h0000_0000;
      endcase
    end
  endfunction

  genvar f;
  generate
    for (f = 0; f < NUM_FANS; f = f + 1) begin : g_fan
      reg  [31:0] spin_cnt_q;
      reg         spin_busy_q;

      fzcr_zone_mux #(
        .NUM_SENSORS (NUM_SENSORS),
        .TEMP_W      (TEMP_W)
      ) u_zone_mux (
        .zone_sel (fan_sel_all[4*f +: 4]),
        .temps    (SENSOR_TEMPS),
        .max_temp (max_temp_q),
        .fan_temp (fan_temp_d[f*TEMP_W +: TEMP_W])
      );

      // a start while already spinning up is ignored, so the phase is never stretched
      always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          spin_cnt_q  <= 32'h0000_0000;
          spin_busy_q <= 1'b0;
        end else if (CORE_CE) begin
          if (!spin_busy_q) begin
            if (FAN_START[f] && (spinup_duration_code != `FZCR_SPIN_NONE)) begin
              spin_cnt_q  <= spin_cycles(spinup_duration_code) - 32'h0000_0001;
              spin_busy_q <= 1'b1;
            end
          end else if (spin_cnt_q == 32'h0000_0000) begin
            spin_busy_q <= 1'b0;
          end else begin
            spin_cnt_q <= spin_cnt_q - 32'h0000_0001;
          end
        end
      end

      assign FAN_SPINUP[f] = spin_busy_q;
    end
  endgenerate

endmodule // fzcr_regs

/* fzcr_regs_chk.sv */
// fzcr_regs_chk.sv: concurrent checks on the ports of fzcr_regs.
// assumes: default sizes (ten 8-bit sensors, four fans) and zero default coefficients.
`timescale 1ns/10ps
module fzcr_regs_chk (
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic        CORE_CE,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic [79:0] SENSOR_TEMPS,
  input wire logic [3:0]  COEF_SENSOR_IDX,
  input wire logic [9:0]  GAIN_COEF,
  input wire logic [8:0]  OFFSET_COEF,
  input wire logic [3:0]  FAN_START,
  input wire logic [3:0]  FAN_SPINUP
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  wire rd_ok = CORE_CE && REG_RD && !REG_WR;
  // write, one idle cycle, then read of the same place
  property p_wr_rd(a);
    (CORE_CE && REG_WR && REG_ADDR == a) ##1 !REG_WR ##1 (rd_ok && REG_ADDR == a)
      |=> REG_RDATA == $past(REG_WDATA, 3);
  endproperty
  AST_RVALID: assert property ((CORE_CE && REG_RD) |=> REG_RVALID) else $error("read not answered");
  AST_NO_RVALID: assert property ((CORE_CE && !REG_RD) |=> !REG_RVALID) else $error("stray answer");
  AST_GOFF: assert property (p_wr_rd(8'h7a)) else $error("0x7a lost data");
  AST_OSPIN: assert property (p_wr_rd(8'h7b)) else $error("0x7b lost data");
  AST_FAN12: assert property (p_wr_rd(8'h7c)) else $error("0x7c lost data");
  AST_FAN34: assert property (p_wr_rd(8'h7d)) else $error("0x7d lost data");
  AST_SENSOR: assert property ((rd_ok && REG_ADDR >= 8'h20 && REG_ADDR <= 8'h29)
    |=> REG_RDATA == $past(SENSOR_TEMPS[(REG_ADDR - 8'h20) * 8 +: 8])) else $error("sensor read wrong");
  // max lags the readings by one edge, so only steady readings are judged
  AST_MAX: assert property ((rd_ok && REG_ADDR == 8'h78 && $stable(SENSOR_TEMPS) && $past(CORE_CE && RESET_N))
    |=> REG_RDATA >= $past(SENSOR_TEMPS[7:0]) && REG_RDATA >= $past(SENSOR_TEMPS[79:72]))
    else $error("max below a reading");
  AST_SPIN_CAUSE: assert property ($rose(FAN_SPINUP[0]) |-> $past(FAN_START[0] && CORE_CE))
    else $error("spin-up without start");
  AST_COEF_DEF: assert property ((CORE_CE && COEF_SENSOR_IDX > 4'h9)
    |=> GAIN_COEF == 10'h000 && OFFSET_COEF == 9'h000) else $error("defaults not used");
  cover property (rd_ok && REG_ADDR == 8'h78);
  cover property ($rose(FAN_SPINUP[3]));
  cover property (CORE_CE && REG_WR && REG_ADDR == 8'h7d);
endmodule // fzcr_regs_chk
bind fzcr_regs fzcr_regs_chk fzcr_regs_chk_inst (.*);

/* fzcr_host.sv */
// fzcr_host.sv: host model issuing byte reads and writes on the register strobes.
// assumes: strobes change at the falling edge of the device clock.
`timescale 1ns/10ps
module fzcr_host (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  initial {addr, wdata, wr, rd} = 18'h0;
  task write(input [7:0] a, input [7:0] d);
    @(negedge clk) {addr, wdata, wr} = {a, d, 1'b1};
    // released data shows the inverse, never a stale copy
    @(negedge clk) {wdata, wr} = {~d, 1'b0};
  endtask
  task read(input [7:0] a, output [7:0] d, output ok);
    @(negedge clk) {addr, rd} = {a, 1'b1};
    @(negedge clk) rd = 1'b0;
    ok = 1'b0;
    repeat (4) if (!ok) begin
      ok = (rvalid === 1'b1);
      if (!ok) @(negedge clk);
    end
    d = rdata;
  endtask
endmodule // fzcr_host

/* fan_zone_coef_regs_tb.sv */
// fan_zone_coef_regs_tb.sv: self-checking bench for fzcr_regs with a host model.
// assumes: spin-up counts shortened to 3..9 cycles for codes 1..7.
`timescale 1ns/10ps
module fan_zone_coef_regs_tb;
  logic clk, rst_n, ce, wr, rd, rvalid;
  logic [7:0] addr, wdata, rdata, v, exp_r[4];
  logic [79:0] temps;
  logic [7:0] ghi;
  logic [9:0] csel, gain;
  logic [3:0] cidx, fstart, fspin;
  logic [8:0] offs;
  logic [31:0] fant;
  logic [15:0] z;
  integer seed = 32'h4423;
  int i, n, n_mismatch = 0, total_checks = 0;
  fzcr_regs #(.SPIN_T1_CYC(3), .SPIN_T2_CYC(4), .SPIN_T3_CYC(5), .SPIN_T4_CYC(6),
    .SPIN_T5_CYC(7), .SPIN_T6_CYC(8), .SPIN_T7_CYC(9)) fzcr_regs_inst (.CORE_CLK(clk), .RESET_N(rst_n),
    .CORE_CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SENSOR_TEMPS(temps), .GAIN_COEF_HI(ghi), .COEF_SELECT(csel),
    .COEF_SENSOR_IDX(cidx), .GAIN_COEF(gain), .OFFSET_COEF(offs), .FAN_TEMPS(fant),
    .FAN_START(fstart), .FAN_SPINUP(fspin));
  fzcr_host host_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function [7:0] f_max(input [79:0] t);
    f_max = 0;
    for (int k = 0; k < 10; k++) if (t[k*8 +: 8] > f_max) f_max = t[k*8 +: 8];
  endfunction
  function [7:0] f_src(input int c, input [79:0] t);
    f_src = (c == 0 || c > 10) ? f_max(t) : t[(c - 1) * 8 +: 8];
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] e);
    total_checks++;
    if (got !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
      n_mismatch++;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    logic [7:0] d;
    logic ok;
    host_inst.read(a, d, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      end_of_test;
    end else chk(d, e);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b0;
    cidx = 4'h0;
    fstart = 4'h0;
    temps = 80'({$random(seed), $random(seed), $random(seed)});
    ghi = 8'($random(seed));
    csel = 10'($random(seed));
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    ce = 1'b1;
    for (i = 0; i < 4; i++) rdc(8'(8'h7a + i), 8'h00);
    for (i = 0; i < 16; i++) begin
      v = 8'($random(seed));
      host_inst.write(8'(8'h7a + i % 4), v);
      exp_r[i % 4] = v;
      rdc(8'(8'h7a + i % 4), v);
    end
    host_inst.write(8'h7e, 8'h5a);
    rdc(8'h7e, 8'h00);
    rdc(8'h7a, exp_r[0]);
    $display("test registers done");
    for (i = 0; i < 16; i++) begin
      temps = 80'({$random(seed), $random(seed), $random(seed)});
      z = {4'(i), 4'(15 - i), 4'(i + 5), 4'(i + 10)};
      host_inst.write(8'h7c, z[15:8]);
      host_inst.write(8'h7d, z[7:0]);
      repeat (3) @(negedge clk);
      chk(fant, {f_src(z[3:0], temps), f_src(z[7:4], temps), f_src(z[11:8], temps), f_src(z[15:12], temps)});
      rdc(8'h78, f_max(temps));
      rdc(8'(8'h20 + i % 10), temps[(i % 10) * 8 +: 8]);
    end
    exp_r[2] = z[15:8];
    $display("test zones done");
    ghi = 8'($random(seed));
    csel = 10'($random(seed));
    // indices 10 to 15 have no select bit and must give the defaults
    for (i = 0; i < 32; i++) begin
      if (i == 16) csel = ~csel;
      cidx = 4'(i % 16);
      repeat (2) @(negedge clk);
      chk(gain, (i % 16 < 10 && csel[i % 16]) ? {ghi, exp_r[0][7:6]} : 10'h000);
      chk(offs, (i % 16 < 10 && csel[i % 16]) ? {exp_r[0][5:0], exp_r[1][7:5]} : 9'h000);
    end
    $display("test coefficients done");
    for (i = 0; i < 8; i++) begin
      host_inst.write(8'h7b, {exp_r[1][7:3], i[2:0]});
      fstart = 4'hf;
      @(negedge clk) fstart = 4'h0;
      n = 0;
      repeat (12) begin
        if (fspin === 4'hf) n++;
        @(negedge clk);
      end
      chk(n, i ? i + 2 : 0);
    end
    $display("test spin-up done");
    // frozen clock enable must not take a write
    ce = 0;
    host_inst.write(8'h7c, ~exp_r[2]);
    ce = 1;
    rdc(8'h7c, exp_r[2]);
    $display("test clock enable done");
    // second reset in mid-run clears the spin-up outputs and brings the four host-writable registers back to zero
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(fspin, 4'h0);
    for (i = 0; i < 4; i++) rdc(8'(8'h7a + i), 8'h00);
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule // fan_zone_coef_regs_tb
